// ==== shared/accum_pkg.sv ====
package accum_pkg;
  // Opcode encodings
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_MAGNITUDE = 3'b001,
    OP_SUM_SHIFT = 3'b010,
    OP_SUM_WITH_CARRY = 3'b011,
    OP_UPPER_HALF_SUM = 3'b100,
    OP_SHORT_IMMEDIATE_SUM = 3'b101,
    OP_CONJUNCTION = 3'b110
  } accum_op_e;
  localparam int ACC_WIDTH = 32;
  localparam int WORD_WIDTH = 16;
  localparam int SHORT_IMM_WIDTH = 8;
  localparam logic [4:0] FIRST_SHIFT_MAX = 5'h10;
  localparam logic [4:0] SECOND_SHIFT_MAX = 5'h0f;
  localparam logic [31:0] ACC_RESET = 32'h0000_0000;
  localparam logic CARRY_RESET = 1'b0;
  localparam logic [31:0] LOW_HALF_MASK = 32'h0000_ffff;
endpackage

// ==== src/accumulator_add_and_abs_unit.sv ====
// What this block does
// - Magnitude op negates a negative accumulator, leaves zero or positive alone
// - Shifted sum: operand shifted left, zero fill, sign extend only in mode
// - First shift count accepts zero through sixteen
// - Second shift count with long immediate limited to zero through fifteen
// - Memory conjunction ANDs low half and clears upper sixteen bits
// - Shifted long constant conjunction treats bits outside the field as zero
// - Shifted sum and conjunction take a sixteen-bit long immediate instead of memory
// - Sum with carry adds memory operand plus carry flag
// - Upper half sum adds operand into upper sixteen, low bits unchanged
// - Upper half sum sets carry on carry out of accumulator top bit
// - Short immediate is eight bits, right justified, never sign extended
`timescale 1ns/1ps
module accumulator_add_and_abs_unit
  import accum_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Instruction from decode
  input wire logic op_valid,
  input wire accum_op_e op_code,
  input wire logic use_long_immediate,
  input wire logic [15:0] data_operand,
  input wire logic [15:0] long_immediate,
  input wire logic [7:0] short_immediate,
  input wire logic [4:0] shift_count,
  input wire logic sign_extend_mode_bit,
  // Accumulator state
  output logic [31:0] accumulator_reg,
  output logic carry_flag,
  output logic shift_refused
);
  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] acc_q;
  logic [31:0] acc_d;
  logic carry_q;
  logic carry_d;
  logic refused_q;
  logic refused_d;
  logic [15:0] sel_operand;
  logic sel_extend;
  logic [4:0] sel_shift;
  logic [31:0] shifted;
  logic [31:0] field_mask;
  logic [32:0] sum;
  logic [16:0] upper_sum;
  logic shift_ok;

  ////////////////////////////////////////////////////////////////////////////
  // Operand selection
  always_comb begin
    sel_operand = use_long_immediate ? long_immediate : data_operand;
    sel_extend = sign_extend_mode_bit;
    sel_shift = shift_count;
    shift_ok = 1'b1;
    case (op_code)
      OP_SUM_SHIFT: begin
        if (use_long_immediate) begin
          shift_ok = (shift_count <= SECOND_SHIFT_MAX);
        end else begin
          shift_ok = (shift_count <= FIRST_SHIFT_MAX);
        end
      end
      OP_CONJUNCTION: begin
        // Constant field is never sign extended, the mask clears around it
        sel_extend = 1'b0;
        if (use_long_immediate) begin
          shift_ok = (shift_count <= FIRST_SHIFT_MAX);
        end else begin
          sel_shift = 5'h00;
        end
      end
      OP_SHORT_IMMEDIATE_SUM: begin
        sel_operand = {8'h00, short_immediate};
        sel_extend = 1'b0;
        sel_shift = 5'h00;
      end
      OP_SUM_WITH_CARRY, OP_UPPER_HALF_SUM: begin
        sel_operand = data_operand;
        sel_shift = 5'h00;
      end
      default: begin
        sel_shift = 5'h00;
      end
    endcase
  end

  operand_shifter u_shifter (
    .operand(sel_operand),
    .extend_sign(sel_extend),
    .shift_count(sel_shift),
    .shifted(shifted),
    .field_mask(field_mask)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Execute
  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    refused_d = 1'b0;
    sum = {1'b0, acc_q} + {1'b0, shifted};
    upper_sum = {1'b0, acc_q[31:16]} + {1'b0, data_operand};
    if (op_valid && !shift_ok) begin
      // Out-of-range count: accumulator held, refusal flagged one cycle
      refused_d = 1'b1;
    end else if (op_valid) begin
      case (op_code)
        OP_MAGNITUDE: begin
          if (acc_q[31]) begin
            acc_d = 32'h0000_0000 - acc_q;
          end
        end
        OP_SUM_SHIFT, OP_SHORT_IMMEDIATE_SUM: begin
          acc_d = sum[31:0];
          carry_d = sum[32];
        end
        OP_SUM_WITH_CARRY: begin
          sum = {1'b0, acc_q} + {1'b0, shifted} + {32'h0000_0000, carry_q};
          acc_d = sum[31:0];
          carry_d = sum[32];
        end
        OP_UPPER_HALF_SUM: begin
          acc_d = {upper_sum[15:0], acc_q[15:0]};
          // Only a carry sets the flag; no carry leaves it as it was
          if (upper_sum[16]) begin
            carry_d = 1'b1;
          end
        end
        OP_CONJUNCTION: begin
          if (use_long_immediate) begin
            acc_d = acc_q & shifted & field_mask;
          end else begin
            acc_d = acc_q & shifted & LOW_HALF_MASK;
          end
        end
        default: begin
          acc_d = acc_q;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      acc_q <= ACC_RESET;
      carry_q <= CARRY_RESET;
      refused_q <= 1'b0;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
      refused_q <= refused_d;
    end
  end

  assign accumulator_reg = acc_q;
  assign carry_flag = carry_q;
  assign shift_refused = refused_q;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_neg_magnitude;
    op_valid && op_code == OP_MAGNITUDE && acc_q[31];
  endsequence

  property p_magnitude;
    @(posedge clk_sys) disable iff (!reset_n)
    s_neg_magnitude |=> acc_q == 32'h0000_0000 - $past(acc_q);
  endproperty
  a_magnitude: assert property (p_magnitude) else $error("negative accumulator not negated");

  property p_magnitude_pos;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_MAGNITUDE && !acc_q[31] |=> $stable(acc_q);
  endproperty
  a_magnitude_pos: assert property (p_magnitude_pos) else $error("positive accumulator changed");

  property p_second_shift;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_SUM_SHIFT && use_long_immediate && shift_count > 5'h0f
      |=> shift_refused && $stable(acc_q);
  endproperty
  a_second_shift: assert property (p_second_shift) else $error("second shift over 15 taken");

  property p_first_shift;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_SUM_SHIFT && !use_long_immediate && shift_count <= 5'h10
      |=> !shift_refused;
  endproperty
  a_first_shift: assert property (p_first_shift) else $error("first shift 0 to 16 refused");

  property p_and_mem;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_CONJUNCTION && !use_long_immediate
      |=> acc_q[31:16] == 16'h0000 && acc_q[15:0] == ($past(acc_q[15:0]) & $past(data_operand));
  endproperty
  a_and_mem: assert property (p_and_mem) else $error("memory AND result wrong");

  property p_short_imm;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_SHORT_IMMEDIATE_SUM
      |=> acc_q == $past(acc_q) + {24'h000000, $past(short_immediate)};
  endproperty
  a_short_imm: assert property (p_short_imm) else $error("short immediate sum wrong");

  property p_upper_low;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_UPPER_HALF_SUM
      |=> acc_q[15:0] == $past(acc_q[15:0])
        && acc_q[31:16] == $past(acc_q[31:16]) + $past(data_operand);
  endproperty
  a_upper_low: assert property (p_upper_low) else $error("upper half sum wrong");

  property p_upper_carry;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_UPPER_HALF_SUM
      && ({1'b0, acc_q[31:16]} + {1'b0, data_operand}) > 17'h0ffff |=> carry_flag;
  endproperty
  a_upper_carry: assert property (p_upper_carry) else $error("upper half carry not set");

  property p_carry_sum;
    @(posedge clk_sys) disable iff (!reset_n)
    op_valid && op_code == OP_SUM_WITH_CARRY
      |=> {carry_flag, acc_q} == {1'b0, $past(acc_q)}
        + {1'b0, {16{$past(sign_extend_mode_bit) & $past(data_operand[15])}}, $past(data_operand)}
        + {32'h0000_0000, $past(carry_q)};
  endproperty
  a_carry_sum: assert property (p_carry_sum) else $error("sum with carry wrong");
endmodule // accumulator_add_and_abs_unit

// ==== src/operand_shifter.sv ====
`timescale 1ns/1ps
module operand_shifter
  import accum_pkg::*;
(
  // Operand in
  input wire logic [15:0] operand,
  input wire logic extend_sign,
  input wire logic [4:0] shift_count,
  // Shifted operand out
  output logic [31:0] shifted,
  output logic [31:0] field_mask
);
  logic [31:0] widened;
  always_comb begin
    // Upper bits copy the sign only when extension is allowed
    widened = extend_sign ? {{WORD_WIDTH{operand[15]}}, operand} : {16'h0000, operand};
    // Left shift fills vacated low bits with zeros
    shifted = widened << shift_count;
    field_mask = LOW_HALF_MASK << shift_count;
  end
endmodule // operand_shifter

// ==== tb/op_source.sv ====
`timescale 1ns/1ps
module op_source
  import accum_pkg::*;
(
  // Clock
  input wire logic clk_sys,
  // Decoded operation
  output logic op_valid,
  output accum_op_e op_code,
  output logic use_long_immediate,
  output logic [15:0] data_operand,
  output logic [15:0] long_immediate,
  output logic [7:0] short_immediate,
  output logic [4:0] shift_count,
  output logic sign_extend_mode_bit
);
  initial begin
    op_valid = 1'b0;
    op_code = OP_NONE;
    use_long_immediate = 1'b0;
    data_operand = 16'h0000;
    long_immediate = 16'hffff;
    short_immediate = 8'h00;
    shift_count = 5'h00;
    sign_extend_mode_bit = 1'b0;
  end
  ////////////////////////////////////////
  // One op for one cycle; unused source carries the inverse so a wrong pick shows
  task issue(input accum_op_e o, input logic l, input logic [15:0] d, input logic [7:0] k,
             input logic [4:0] s, input logic x);
    @(negedge clk_sys);
    op_valid = 1'b1;
    op_code = o;
    use_long_immediate = l;
    data_operand = l ? ~d : d;
    long_immediate = l ? d : ~d;
    short_immediate = k;
    shift_count = s;
    sign_extend_mode_bit = x;
    @(negedge clk_sys);
    op_valid = 1'b0;
    data_operand = ~data_operand;
    long_immediate = ~long_immediate;
  endtask
endmodule // op_source

// ==== tb/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  import accum_pkg::*;
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic op_valid, use_long_immediate, sign_extend_mode_bit, carry_flag, shift_refused;
  accum_op_e op_code;
  logic [15:0] data_operand, long_immediate;
  logic [7:0] short_immediate;
  logic [4:0] shift_count;
  logic [31:0] accumulator_reg, acc_e;
  logic c_e;
  int n_mismatch = 0;
  int n_tests = 0;
  always #2 clk_sys = ~clk_sys;
  op_source src_u(.clk_sys(clk_sys), .op_valid(op_valid), .op_code(op_code),
    .use_long_immediate(use_long_immediate), .data_operand(data_operand),
    .long_immediate(long_immediate), .short_immediate(short_immediate),
    .shift_count(shift_count), .sign_extend_mode_bit(sign_extend_mode_bit));
  accumulator_add_and_abs_unit dut_u(.clk_sys(clk_sys), .reset_n(reset_n),
    .op_valid(op_valid), .op_code(op_code), .use_long_immediate(use_long_immediate),
    .data_operand(data_operand), .long_immediate(long_immediate),
    .short_immediate(short_immediate), .shift_count(shift_count),
    .sign_extend_mode_bit(sign_extend_mode_bit), .accumulator_reg(accumulator_reg),
    .carry_flag(carry_flag), .shift_refused(shift_refused));
  ////////////////////////////////////////
  task chk_acc(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task chk_bit(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // Judged half a cycle after the taking edge, when the registers have settled
  task run(input accum_op_e o, input logic l, input logic [15:0] d, input logic [7:0] k,
           input logic [4:0] s, input logic x, input logic [31:0] a, input logic c,
           input logic rf);
    acc_e = a;
    c_e = c;
    src_u.issue(o, l, d, k, s, x);
    chk_acc(accumulator_reg, acc_e);
    chk_bit(carry_flag, c_e);
    chk_bit(shift_refused, rf);
  endtask
  ////////////////////////////////////////
  task t_reset;
    chk_acc(accumulator_reg, ACC_RESET);
    chk_bit(carry_flag, CARRY_RESET);
    chk_bit(shift_refused, 1'b0);
  endtask
  // Mid-run reset must clear a busy accumulator and a set carry
  task t_mid_reset;
    @(negedge clk_sys);
    reset_n = 1'b0;
    @(negedge clk_sys);
    reset_n = 1'b1;
    t_reset();
  endtask
  task t_sum;
    run(OP_SUM_SHIFT, 0, 16'h8001, 0, 5'h10, 1, 32'h80010000, 0, 0);
    run(OP_SUM_SHIFT, 0, 16'hf00d, 0, 5'h04, 0, 32'h801000d0, 0, 0);
    run(OP_SUM_SHIFT, 1, 16'h8000, 0, 5'h0f, 1, 32'h401000d0, 1, 0);
    run(OP_SUM_SHIFT, 1, 16'h0001, 0, 5'h10, 0, acc_e, c_e, 1);
    run(OP_SUM_SHIFT, 0, 16'h0001, 0, 5'h11, 0, acc_e, c_e, 1);
    run(OP_SHORT_IMMEDIATE_SUM, 0, 16'h0, 8'hff, 0, 1, 32'h401001cf, 0, 0);
  endtask
  task t_high;
    run(OP_UPPER_HALF_SUM, 0, 16'hc000, 0, 0, 1, 32'h001001cf, 1, 0);
    run(OP_UPPER_HALF_SUM, 0, 16'h8000, 0, 0, 1, 32'h801001cf, 1, 0);
  endtask
  task t_carry;
    run(OP_SUM_WITH_CARRY, 0, 16'h0010, 0, 0, 0, 32'h801001e0, 0, 0);
    run(OP_SUM_WITH_CARRY, 0, 16'hffff, 0, 0, 1, 32'h801001df, 1, 0);
  endtask
  task t_abs;
    run(OP_MAGNITUDE, 0, 16'h0, 0, 0, 0, 32'h7feffe21, 1, 0);
    run(OP_MAGNITUDE, 0, 16'h0, 0, 0, 0, 32'h7feffe21, 1, 0);
  endtask
  task t_and;
    // Upper half still busy here, so bits above the constant field are really tested
    run(OP_CONJUNCTION, 1, 16'h8f07, 8'h00, 5'h04, 1, 32'h0008f020, 1, 0);
    run(OP_CONJUNCTION, 0, 16'h3f3f, 8'h00, 5'h00, 0, 32'h00003020, 1, 0);
    run(OP_CONJUNCTION, 1, 16'hffff, 0, 5'h11, 0, acc_e, c_e, 1);
    run(OP_NONE, 1, 16'hffff, 8'hff, 5'h00, 1, acc_e, c_e, 0);
  endtask
  ////////////////////////////////////////
  task conclude;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // About 38 cycles of traffic; a wide margin still ends a hang quickly
  initial begin
    repeat (2000) @(posedge clk_sys);
    n_mismatch++;
    conclude();
  end
  initial begin
    repeat (4) @(negedge clk_sys);
    reset_n = 1'b1;
    t_reset();
    t_sum();
    t_high();
    t_carry();
    t_abs();
    t_and();
    t_mid_reset();
    conclude();
  end
endmodule // tb_top
